// [pao_adc_port.sv]
`default_nettype none
module pao_adc_port #(
  parameter int unsigned AIN_W = pao_pkg::AIN_W,
  parameter int unsigned RES_W = pao_pkg::RES_W
) (
  input  wire logic               CLK,
  input  wire logic               RST,
  input  wire logic [AIN_W-1:0]   ANALOG_INPUT_POSITIVE,
  input  wire logic [AIN_W-1:0]   ANALOG_INPUT_NEGATIVE,
  input  wire logic               OUTPUT_ENABLE_N,
  input  wire logic               SHUTDOWN_REQUEST,
  output logic [11:0]             SAMPLE_CODE_BUS_O,
  output logic [11:0]             SAMPLE_CODE_BUS_OE,
  output logic                    SHUTDOWN_ACTIVE
);
  localparam int unsigned NST  = pao_pkg::STAGES;
  localparam int unsigned NLV  = pao_pkg::LEVELS;
  localparam int unsigned DW   = pao_pkg::DIG_W;
  localparam int unsigned SW   = pao_pkg::SUM_W;
  localparam int unsigned LAT  = pao_pkg::LATENCY;
  localparam int unsigned FILL_W = $clog2(LAT);
  localparam logic [FILL_W-1:0] FILL_LAST = FILL_W'(LAT - 1);

  // Operating modes, one-hot
  typedef enum logic [2:0] {
    MODE_FILL = 3'b001,  // Pipe holds fewer than seven running samples
    MODE_RUN  = 3'b010,  // Every edge without a shutdown request hands a finished code to the latch
    MODE_HALT = 3'b100   // Shutdown; the latch keeps its code
  } pao_mode_e;

  // Pipeline storage: level 0 is the sample, levels 1..6 follow two stages each
  logic signed [RES_W-1:0] res_reg   [0:NLV];
  logic [DW-1:0]           dig_reg   [1:NLV];
  logic [DW-1:0]           dig_in    [1:NLV];
  logic signed [RES_W-1:0] stage_res [0:NST-1];
  logic                    stage_hi  [0:NST-1];
  logic                    stage_lo  [0:NST-1];
  logic [FILL_W-1:0]       fill_reg;
  pao_mode_e               mode_reg;
  pao_mode_e               mode_next;
  logic [SW-1:0]           term      [0:NST-1];
  logic [SW-1:0]           acc_sum;
  logic [11:0]             code_reg;
  logic [11:0]             code_next;
  logic [11:0]             oe_reg;
  logic                    shut_reg;
  logic signed [AIN_W:0]   diff_in;
  logic signed [RES_W-1:0] sample_next;

  // Differential input halved so it lands inside the residue full scale
  always_comb begin
    diff_in     = $signed({1'b0, ANALOG_INPUT_POSITIVE}) - $signed({1'b0, ANALOG_INPUT_NEGATIVE});
    sample_next = RES_W'(diff_in >>> 1);
  end

  // Sample taken on the rising edge; the latency count starts here
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      res_reg[0] <= '0;
    end else begin
      res_reg[0] <= sample_next;
    end
  end

  // Twelve stages, two per clock level, each resolving one bit
  genvar j;
  generate
    for (j = 0; j < NST; j++) begin : g_stage
      logic signed [RES_W-1:0] held;
      if (j % 2 == 0) begin : g_from_reg
        assign held = res_reg[j / 2];
      end else begin : g_from_half
        assign held = stage_res[j - 1];
      end
      pao_stage #(
        .RES_W (RES_W)
      ) u_stage (
        .held_in     (held),
        .cmp_hi      (stage_hi[j]),
        .cmp_lo      (stage_lo[j]),
        .residue_out (stage_res[j])
      );
    end
  endgenerate

  // Level registers carry the residue and all stage codes resolved so far.
  // The codes travel with their sample so correction sees one sample's bits.
  genvar k;
  generate
    for (k = 1; k <= NLV; k++) begin : g_level
      logic [DW-1:0] new_bits;
      if (k == 1) begin : g_first
        assign dig_in[k] = '0;
      end else begin : g_rest
        assign dig_in[k] = dig_reg[k - 1];
      end
      assign new_bits = {{(DW - 4){1'b0}},
                         stage_hi[2 * k - 1], stage_lo[2 * k - 1],
                         stage_hi[2 * k - 2], stage_lo[2 * k - 2]} << (4 * k - 4);
      always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
          res_reg[k] <= '0;
          dig_reg[k] <= '0;
        end else begin
          res_reg[k] <= stage_res[2 * k - 1];
          dig_reg[k] <= dig_in[k] | new_bits;
        end
      end
    end
  endgenerate

  // Redundant correction: each stage weighs hi+lo-1 at its binary weight.
  // Offset of all -1 terms folds into a +1, so zero input lands on midscale
  // and the halving keeps the result inside 0..4095 without clamping.
  genvar m;
  generate
    for (m = 0; m < NST; m++) begin : g_weight
      assign term[m] = (SW'(dig_reg[NLV][2 * m + 1]) + SW'(dig_reg[NLV][2 * m])) << (NST - 1 - m);
    end
  endgenerate

  // Adder chain over the weighted terms, then offset and halve
  always_comb begin
    acc_sum = '0;
    for (int i = 0; i < NST; i++) begin
      acc_sum = acc_sum + term[i];
    end
    code_next = 12'((acc_sum + SW'(1)) >> 1);
  end

  // Shutdown state follows the request pin directly
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      shut_reg <= 1'b0;
    end else begin
      shut_reg <= SHUTDOWN_REQUEST;
    end
  end

  // Mode: shutdown wins, and a wake-up refills the pipe before the latch
  // moves again, so samples taken during shutdown never reach the bus.
  always_comb begin
    mode_next = mode_reg;
    if (SHUTDOWN_REQUEST) begin
      mode_next = MODE_HALT;
    end else begin
      unique case (mode_reg)
        MODE_HALT: begin
          mode_next = MODE_FILL;
        end
        MODE_FILL: begin
          if (fill_reg == FILL_LAST) begin
            mode_next = MODE_RUN;
          end
        end
        MODE_RUN: begin
          mode_next = MODE_RUN;
        end
      endcase
    end
  end

  // Mode register
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      mode_reg <= MODE_FILL;
    end else begin
      mode_reg <= mode_next;
    end
  end

  // Running samples since reset or wake-up, saturating; shutdown clears it
  // because the samples in flight then are dropped.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      fill_reg <= '0;
    end else if (SHUTDOWN_REQUEST) begin
      fill_reg <= '0;
    end else if (fill_reg != FILL_LAST) begin
      fill_reg <= fill_reg + FILL_W'(1);
    end
  end

  // Output latch: one update per clock in MODE_RUN, held through shutdown
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      code_reg <= pao_pkg::CODE_RESET;
    end else if (SHUTDOWN_REQUEST) begin
      code_reg <= code_reg;
    end else if (mode_reg == MODE_RUN) begin
      code_reg <= code_next;
    end
  end

  // Bus enable per bit; registered so the pin never glitches mid-cycle
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      oe_reg <= '0;
    end else if (OUTPUT_ENABLE_N) begin
      oe_reg <= '0;
    end else begin
      oe_reg <= '1;
    end
  end

  assign SAMPLE_CODE_BUS_O  = code_reg;
  assign SAMPLE_CODE_BUS_OE = oe_reg;
  assign SHUTDOWN_ACTIVE    = shut_reg;
endmodule : pao_adc_port
`default_nettype wire

// [pao_pkg.sv]
`default_nettype none
// Shared constants of the pipelined converter output port
package pao_pkg;
  // Output code format
  localparam int unsigned CODE_W       = 12;
  localparam logic [11:0] CODE_MIDSCALE = 12'h800;  // Bipolar zero, offset binary
  localparam logic [11:0] CODE_RESET    = 12'h800;

  // Pipeline geometry
  localparam int unsigned STAGES       = 12;
  localparam int unsigned STAGES_PER_CYCLE = 2;      // Two stages settle between rising edges
  localparam int unsigned LEVELS       = STAGES / STAGES_PER_CYCLE;
  localparam int unsigned LATENCY      = 7;          // Sample edge to output edge
  localparam int unsigned DIG_W        = 2 * STAGES; // Two comparator bits per stage

  // Digital stand-in for the analog path
  localparam int unsigned AIN_W        = 13;         // Each input leg, unsigned
  localparam int unsigned RES_W        = 15;         // Signed residue width
  localparam int unsigned SUM_W        = 14;         // Correction adder width

  // Clock figures
  localparam int unsigned CLK_RATE_HZ  = 50000000;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned CLK_MIN_HZ   = 100000;     // Lowest sampling rate allowed
  localparam int unsigned CLK_MAX_HZ   = 60000000;   // Highest sampling rate allowed
endpackage : pao_pkg
`default_nettype wire

// [pao_stage.sv]
`default_nettype none
// One pipeline stage: two comparators at +/- quarter scale, residue doubled
module pao_stage #(
  parameter int unsigned RES_W = 15
) (
  input  wire logic signed [RES_W-1:0] held_in,
  output logic                         cmp_hi,
  output logic                         cmp_lo,
  output logic signed [RES_W-1:0]      residue_out
);
  // Full scale R sits three bits under the width so 2v stays in range
  localparam logic signed [RES_W-1:0] FULL_SCALE = RES_W'(1) <<< (RES_W - 3);
  localparam logic signed [RES_W-1:0] QUARTER    = RES_W'(1) <<< (RES_W - 5);

  logic signed [RES_W-1:0] dac_level;

  // Thermometer code and subtract of the stage DAC level
  always_comb begin
    cmp_hi = (held_in > QUARTER);
    cmp_lo = (held_in > -QUARTER);
    if (cmp_hi) begin
      dac_level = FULL_SCALE;
    end else if (cmp_lo) begin
      dac_level = '0;
    end else begin
      dac_level = -FULL_SCALE;
    end
    residue_out = (held_in <<< 1) - dac_level;  // Doubled error to next stage
  end
endmodule : pao_stage
`default_nettype wire

// [pao_adc_port_monitor.sv]
`default_nettype none
// Port behaviour checked from the top pins only
module pao_adc_port_monitor #(
  parameter int unsigned AIN_W = 13,
  parameter int unsigned RES_W = 15
) (
  input wire logic             CLK,
  input wire logic             RST,
  input wire logic [AIN_W-1:0] ANALOG_INPUT_POSITIVE,
  input wire logic [AIN_W-1:0] ANALOG_INPUT_NEGATIVE,
  input wire logic             OUTPUT_ENABLE_N,
  input wire logic             SHUTDOWN_REQUEST,
  input wire logic [11:0]      SAMPLE_CODE_BUS_O,
  input wire logic [11:0]      SAMPLE_CODE_BUS_OE,
  input wire logic             SHUTDOWN_ACTIVE
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [AIN_W-1:0] FS = '1;
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // Eight running edges: the oldest sample has fully crossed the pipe
  sequence s_run(c);
    (!SHUTDOWN_REQUEST && c)[*8];
  endsequence
  a_bus_released: assert property (OUTPUT_ENABLE_N |=> SAMPLE_CODE_BUS_OE == 12'h000)
    else $error("bus not released");
  a_bus_driven: assert property (!OUTPUT_ENABLE_N |=> SAMPLE_CODE_BUS_OE == 12'hfff)
    else $error("bus not driven");
  a_sd_enter: assert property (SHUTDOWN_REQUEST |=> SHUTDOWN_ACTIVE)
    else $error("shutdown not entered");
  a_sd_leave: assert property (!SHUTDOWN_REQUEST |=> !SHUTDOWN_ACTIVE)
    else $error("shutdown not left");
  a_code_frozen: assert property (SHUTDOWN_REQUEST |=> $stable(SAMPLE_CODE_BUS_O))
    else $error("code moved in shutdown");
  a_mid_code: assert property (s_run(ANALOG_INPUT_POSITIVE == ANALOG_INPUT_NEGATIVE)
    |=> SAMPLE_CODE_BUS_O == 12'h800) else $error("bad midscale code");
  a_top_code: assert property (s_run(ANALOG_INPUT_POSITIVE == FS && ANALOG_INPUT_NEGATIVE == 0)
    |=> SAMPLE_CODE_BUS_O == 12'hfff) else $error("bad top code");
  a_bottom_code: assert property (s_run(ANALOG_INPUT_POSITIVE == 0 && ANALOG_INPUT_NEGATIVE == FS)
    |=> SAMPLE_CODE_BUS_O == 12'h000) else $error("bad bottom code");
  // Wake-up refill: the latch keeps its code until the first fresh sample lands
  sequence s_refill;
    $stable(SAMPLE_CODE_BUS_O)[*8];
  endsequence
  a_wake_refill: assert property ($fell(SHUTDOWN_REQUEST) |-> s_refill)
    else $error("code moved before refill");
endmodule // pao_adc_port_monitor
bind pao_adc_port pao_adc_port_monitor #(.AIN_W(AIN_W), .RES_W(RES_W)) u_mon (.*);
`default_nettype wire

// [pao_capture.sv]
`default_nettype none
// Capture side: resolves the three-state bus as read
module pao_capture (
  input wire logic        clk,
  input wire logic [11:0] bus_o,
  input wire logic [11:0] bus_oe,
  output logic [11:0]     bus_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [11:0] last_reg;
  // Released bits float; inverting stops stale data looking valid
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      bus_seen[i] = bus_oe[i] ? bus_o[i] : ~last_reg[i];
    end
  end
  // Remember the last level actually driven on each bit
  always_ff @(posedge clk) begin
    for (int i = 0; i < 12; i++) begin
      if (bus_oe[i]) begin
        last_reg[i] <= bus_o[i];
      end
    end
  end
endmodule // pao_capture
`default_nettype wire

// [tb_pipelined_adc_output_port.sv]
`default_nettype none
// Self-checking bench for the converter output port
module tb_pipelined_adc_output_port;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [12:0] FS = 13'h1fff;
  logic        clk, rst, oe_n, sd, sd_act;
  logic [12:0] p, n;
  logic [11:0] bus_o, bus_oe, seen;
  int          n_fail, compares, cycles;
  // 50 MHz, inside the permitted sampling range
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  pao_adc_port u_dut (.CLK(clk), .RST(rst), .ANALOG_INPUT_POSITIVE(p), .ANALOG_INPUT_NEGATIVE(n),
    .OUTPUT_ENABLE_N(oe_n), .SHUTDOWN_REQUEST(sd), .SAMPLE_CODE_BUS_O(bus_o),
    .SAMPLE_CODE_BUS_OE(bus_oe), .SHUTDOWN_ACTIVE(sd_act));
  pao_capture u_cap (.clk(clk), .bus_o(bus_o), .bus_oe(bus_oe), .bus_seen(seen));
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH %0t flag got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Apply one input pair at the next edge, then let k edges pass
  task automatic go(input logic [12:0] pv, input logic [12:0] nv, input int k);
    @(posedge clk);
    p <= pv;
    n <= nv;
    repeat (k) @(posedge clk);
  endtask
  // One odd sample in a bottom-code stream must surface on the seventh edge only
  task automatic t_pulse(input logic [12:0] pv, input logic [12:0] nv, input logic [11:0] exp);
    go(13'h0, FS, 10);
    go(pv, nv, 0);
    go(13'h0, FS, 0);
    for (int k = 1; k < 10; k++) begin
      @(negedge clk);
      chk(bus_o, (k == 8) ? exp : 12'h000);
    end
  endtask
  task automatic t_enable();
    @(posedge clk);
    oe_n <= 1'b1;
    repeat (2) @(negedge clk);
    chk(bus_oe, 12'h000);
    chk(seen, 12'hfff);
    @(posedge clk);
    oe_n <= 1'b0;
    repeat (2) @(negedge clk);
    chk(bus_oe, 12'hfff);
    chk(seen, 12'h000);
  endtask
  // Inputs change during shutdown, yet the bus keeps the last code
  task automatic t_shutdown();
    go(FS, 13'h0, 10);
    go(13'h0, FS, 0);
    sd <= 1'b1;
    repeat (9) @(negedge clk);
    chk(seen, 12'hfff);
    chk_flag(sd_act, 1'b1);
    @(posedge clk);
    sd <= 1'b0;
    repeat (10) @(negedge clk);
    chk(bus_o, 12'h000);
    chk_flag(sd_act, 1'b0);
  endtask
  // Hang guard: the run needs well under 1000 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      n_fail++;
      report_and_stop();
    end
  end
  initial begin
    rst = 1'b1;
    oe_n = 1'b0;
    sd = 1'b0;
    p = 13'h0;
    n = 13'h0;
    n_fail = 0;
    compares = 0;
    cycles = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    go(13'h0, 13'h0, 10);
    @(negedge clk);
    chk(bus_o, 12'h800);
    t_pulse(FS, 13'h0, 12'hfff);
    t_pulse(13'h0a5, 13'h0a5, 12'h800);
    t_pulse(13'h004, 13'h000, 12'h801);
    t_pulse(13'h000, 13'h004, 12'h7ff);
    t_enable();
    t_shutdown();
    report_and_stop();
  end
endmodule // tb_pipelined_adc_output_port
`default_nettype wire
